// *** urs_bank.sv ***
// Purpose: Per-channel register bank with reset defaults, flow characters and FIFO status.
// Assumes: Host strobes and status inputs are synchronous to I_CLK.
// Notes: Reads return data one edge after the strobe edge; the status select wins the bus.
`timescale 1ns/1ps
module urs_bank #(
	parameter bit TRISTATE_INT = 1'b1,
	parameter int NCH = urs_pkg::NCH
) (
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic I_CS_N,
	input wire logic [1:0] I_CH,
	input wire logic [urs_pkg::AW-1:0] I_ADDR,
	input wire logic I_RD_N,
	input wire logic I_WR_N,
	input wire logic [7:0] I_DATA,
	input wire logic I_STATUS_READ_SELECT_N,
	input wire logic I_BUS_ALT_MODE,
	input wire logic I_INTERRUPT_STYLE_SELECT,
	input wire logic [NCH-1:0][3:0] I_MODEM_N,
	input wire urs_pkg::urs_stat_t [NCH-1:0] I_STAT,
	input wire logic [NCH-1:0] I_TX_SPACE,
	input wire logic [NCH-1:0] I_RX_AVAIL,
	input wire logic [NCH-1:0] I_TX_SER,
	input wire logic [NCH-1:0] I_IR_SER,
	output logic [7:0] O_DATA,
	output logic O_DATA_OE,
	output logic [NCH-1:0] O_TX,
	output logic [NCH-1:0] O_INFRARED_TX_OUT,
	output logic [NCH-1:0] O_RTS_N,
	output logic [NCH-1:0] O_DTR_N,
	output logic [NCH-1:0] O_TX_SPACE_READY_N,
	output logic [NCH-1:0] O_RX_DATA_READY_N,
	output logic O_INT,
	output logic O_INT_OE,
	output logic O_IRQ_N,
	output logic O_IRQ_N_OE
);
	logic [7:0] ier_reg [NCH];
	logic [7:0] fcr_reg [NCH];
	logic [7:0] lcr_reg [NCH];
	logic [7:0] mcr_reg [NCH];
	logic [7:0] spr_reg [NCH];
	logic [7:0] enhanced_mode_select_reg_reg [NCH];
	logic [7:0] trg_reg [NCH];
	logic [7:0] feature_control_reg_reg [NCH];
	logic [7:0] efr_reg [NCH];
	logic [7:0] xon_char_one_reg [NCH];
	logic [7:0] xon_char_two_reg [NCH];
	logic [7:0] xoff_char_one_reg [NCH];
	logic [7:0] xoff_char_two_reg [NCH];
	urs_pkg::urs_stat_t stat_reg [NCH];
	logic [3:0] msr_hi_reg [NCH];
	logic [7:0] fifo_ready_status_reg;
	logic rd_act_reg;
	logic wr_act_reg;
	logic [7:0] stage_reg;
	logic stage_mem_reg;
	logic [7:0] mem_rdata;

	wire rd_act = !I_CS_N && !I_RD_N;
	wire wr_act = !I_CS_N && !I_WR_N;
	wire rd_start = rd_act && !rd_act_reg;
	wire wr_pulse = wr_act && !wr_act_reg;
	wire swap = feature_control_reg_reg[I_CH][urs_pkg::FEATURE_CONTROL_REG_SWAP_BIT];
	wire wr_ier = wr_pulse && I_ADDR == urs_pkg::OFS_IER;
	wire wr_fcr = wr_pulse && I_ADDR == urs_pkg::OFS_ISR;
	wire wr_lcr = wr_pulse && I_ADDR == urs_pkg::OFS_LCR;
	wire wr_mcr = wr_pulse && I_ADDR == urs_pkg::OFS_MCR;
	wire wr_spr = wr_pulse && I_ADDR == urs_pkg::OFS_SPR && !swap;
	wire wr_enhanced_mode_select_reg = wr_pulse && (I_ADDR == urs_pkg::OFS_ENHANCED_MODE_SELECT_REG ||
		(I_ADDR == urs_pkg::OFS_SPR && swap));
	wire wr_trg = wr_pulse && I_ADDR == urs_pkg::OFS_TRG;
	wire wr_feature_control_reg = wr_pulse && I_ADDR == urs_pkg::OFS_FEATURE_CONTROL_REG;
	wire wr_efr = wr_pulse && I_ADDR == urs_pkg::OFS_EFR;
	wire wr_xon_char_one = wr_pulse && I_ADDR == urs_pkg::OFS_XON_CHAR_ONE;
	wire wr_xon_char_two = wr_pulse && I_ADDR == urs_pkg::OFS_XON_CHAR_TWO;
	wire wr_xoff_char_one = wr_pulse && I_ADDR == urs_pkg::OFS_XOFF_CHAR_ONE;
	wire wr_xoff_char_two = wr_pulse && I_ADDR == urs_pkg::OFS_XOFF_CHAR_TWO;

	// Divisor and holding bytes sit in unreset storage.
	wire [1:0] wslot = (I_ADDR == urs_pkg::OFS_DLL) ? urs_pkg::SLOT_DLL :
		(I_ADDR == urs_pkg::OFS_DLM) ? urs_pkg::SLOT_DLM : urs_pkg::SLOT_THR;
	wire is_mem_wr = I_ADDR == urs_pkg::OFS_DLL || I_ADDR == urs_pkg::OFS_DLM ||
		I_ADDR == urs_pkg::OFS_HOLD;
	wire [1:0] rslot = (I_ADDR == urs_pkg::OFS_DLL) ? urs_pkg::SLOT_DLL :
		(I_ADDR == urs_pkg::OFS_DLM) ? urs_pkg::SLOT_DLM : urs_pkg::SLOT_RHR;
	wire mem_we = wr_pulse && is_mem_wr;

	urs_mem #(.W(8), .DEPTH(16), .AW(4)) u_mem (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_we(mem_we),
		.i_waddr({I_CH, wslot}),
		.i_wdata(I_DATA),
		.i_raddr({I_CH, rslot}),
		.o_rdata(mem_rdata)
	);

	// With the swap bit set the scratchpad slot reads the FIFO count instead.
	wire [7:0] msr_val = {msr_hi_reg[I_CH], stat_reg[I_CH].delta};
	wire [7:0] reg_rd =
		(I_ADDR == urs_pkg::OFS_IER) ? ier_reg[I_CH] :
		(I_ADDR == urs_pkg::OFS_ISR) ? stat_reg[I_CH].interrupt_source_reg :
		(I_ADDR == urs_pkg::OFS_LCR) ? lcr_reg[I_CH] :
		(I_ADDR == urs_pkg::OFS_MCR) ? mcr_reg[I_CH] :
		(I_ADDR == urs_pkg::OFS_LSR) ? stat_reg[I_CH].line_status_reg :
		(I_ADDR == urs_pkg::OFS_MSR) ? msr_val :
		(I_ADDR == urs_pkg::OFS_SPR) ? (swap ? stat_reg[I_CH].fcnt : spr_reg[I_CH]) :
		(I_ADDR == urs_pkg::OFS_ENHANCED_MODE_SELECT_REG) ? enhanced_mode_select_reg_reg[I_CH] :
		(I_ADDR == urs_pkg::OFS_FIFO_LEVEL_REG) ? stat_reg[I_CH].fifo_level_reg :
		(I_ADDR == urs_pkg::OFS_TRG) ? trg_reg[I_CH] :
		(I_ADDR == urs_pkg::OFS_FCNT) ? stat_reg[I_CH].fcnt :
		(I_ADDR == urs_pkg::OFS_FEATURE_CONTROL_REG) ? feature_control_reg_reg[I_CH] :
		(I_ADDR == urs_pkg::OFS_EFR) ? efr_reg[I_CH] :
		(I_ADDR == urs_pkg::OFS_XON_CHAR_ONE) ? xon_char_one_reg[I_CH] :
		(I_ADDR == urs_pkg::OFS_XON_CHAR_TWO) ? xon_char_two_reg[I_CH] :
		(I_ADDR == urs_pkg::OFS_XOFF_CHAR_ONE) ? xoff_char_one_reg[I_CH] :
		(I_ADDR == urs_pkg::OFS_XOFF_CHAR_TWO) ? xoff_char_two_reg[I_CH] : urs_pkg::RST_ZERO;
	wire reg_is_mem = I_ADDR == urs_pkg::OFS_DLL || I_ADDR == urs_pkg::OFS_DLM ||
		I_ADDR == urs_pkg::OFS_HOLD;

	logic [NCH-1:0] pend;
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			pend[c] = !stat_reg[c].interrupt_source_reg[urs_pkg::ISR_NONE_BIT];
		end
	end
	wire any_pend = |pend;
	wire irq_mode = I_BUS_ALT_MODE && !I_INTERRUPT_STYLE_SELECT;

	// Every channel resets together on the one reset input.
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			for (int c = 0; c < NCH; c++) begin
				ier_reg[c] <= urs_pkg::RST_ZERO;
				fcr_reg[c] <= urs_pkg::RST_ZERO;
				lcr_reg[c] <= urs_pkg::RST_ZERO;
				mcr_reg[c] <= urs_pkg::RST_ZERO;
				spr_reg[c] <= urs_pkg::RST_SPR;
				enhanced_mode_select_reg_reg[c] <= urs_pkg::RST_ZERO;
				trg_reg[c] <= urs_pkg::RST_ZERO;
				feature_control_reg_reg[c] <= urs_pkg::RST_ZERO;
				efr_reg[c] <= urs_pkg::RST_ZERO;
				xon_char_one_reg[c] <= urs_pkg::RST_ZERO;
				xon_char_two_reg[c] <= urs_pkg::RST_ZERO;
				xoff_char_one_reg[c] <= urs_pkg::RST_ZERO;
				xoff_char_two_reg[c] <= urs_pkg::RST_ZERO;
			end
		end else begin
			if (wr_ier) ier_reg[I_CH] <= I_DATA;
			if (wr_fcr) fcr_reg[I_CH] <= I_DATA;
			if (wr_lcr) lcr_reg[I_CH] <= I_DATA;
			if (wr_mcr) mcr_reg[I_CH] <= I_DATA;
			if (wr_spr) spr_reg[I_CH] <= I_DATA;
			if (wr_enhanced_mode_select_reg) enhanced_mode_select_reg_reg[I_CH] <= I_DATA;
			if (wr_trg) trg_reg[I_CH] <= I_DATA;
			if (wr_feature_control_reg) feature_control_reg_reg[I_CH] <= I_DATA;
			if (wr_efr) efr_reg[I_CH] <= I_DATA;
			if (wr_xon_char_one) xon_char_one_reg[I_CH] <= I_DATA;
			if (wr_xon_char_two) xon_char_two_reg[I_CH] <= I_DATA;
			if (wr_xoff_char_one) xoff_char_one_reg[I_CH] <= I_DATA;
			if (wr_xoff_char_two) xoff_char_two_reg[I_CH] <= I_DATA;
		end
	end

	// Engine status is copied each edge; reset shows the idle values.
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			for (int c = 0; c < NCH; c++) begin
				stat_reg[c].interrupt_source_reg <= urs_pkg::RST_ISR;
				stat_reg[c].line_status_reg <= urs_pkg::RST_LSR;
				stat_reg[c].fifo_level_reg <= urs_pkg::RST_ZERO;
				stat_reg[c].fcnt <= urs_pkg::RST_ZERO;
				stat_reg[c].delta <= urs_pkg::RST_DELTA;
			end
		end else begin
			for (int c = 0; c < NCH; c++) begin
				stat_reg[c] <= I_STAT[c];
			end
		end
	end

	// No reset here on purpose: the input levels must show even while reset is held.
	always_ff @(posedge I_CLK) begin
		for (int c = 0; c < NCH; c++) begin
			msr_hi_reg[c] <= ~I_MODEM_N[c];
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_TX <= '1;
			O_INFRARED_TX_OUT <= '0;
			O_RTS_N <= '1;
			O_DTR_N <= '1;
			O_RX_DATA_READY_N <= '1;
			O_TX_SPACE_READY_N <= '0;
			fifo_ready_status_reg <= urs_pkg::RST_FIFO_READY_STATUS;
		end else begin
			O_TX <= I_TX_SER;
			O_INFRARED_TX_OUT <= I_IR_SER;
			for (int c = 0; c < NCH; c++) begin
				O_RTS_N[c] <= !mcr_reg[c][urs_pkg::MCR_RTS_BIT];
				O_DTR_N[c] <= !mcr_reg[c][urs_pkg::MCR_DTR_BIT];
			end
			O_RX_DATA_READY_N <= ~I_RX_AVAIL;
			O_TX_SPACE_READY_N <= ~I_TX_SPACE;
			fifo_ready_status_reg <= {O_RX_DATA_READY_N, ~O_TX_SPACE_READY_N};
		end
	end

	// The tristate variant floats the line on reset, the continuous one drives it low.
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_INT <= 1'b0;
			O_INT_OE <= !TRISTATE_INT;
			O_IRQ_N <= 1'b1;
			O_IRQ_N_OE <= 1'b1;
		end else begin
			O_INT <= any_pend;
			O_INT_OE <= TRISTATE_INT ? any_pend : 1'b1;
			O_IRQ_N <= !any_pend;
			O_IRQ_N_OE <= irq_mode;
		end
	end

	// Two-stage read path keeps the bus data coming from a flop.
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rd_act_reg <= 1'b0;
			wr_act_reg <= 1'b0;
			stage_reg <= urs_pkg::RST_ZERO;
			stage_mem_reg <= 1'b0;
			O_DATA <= urs_pkg::RST_ZERO;
			O_DATA_OE <= 1'b0;
		end else begin
			rd_act_reg <= rd_act;
			wr_act_reg <= wr_act;
			if (rd_start) begin
				stage_reg <= reg_rd;
				stage_mem_reg <= reg_is_mem;
			end
			if (!I_STATUS_READ_SELECT_N) begin
				O_DATA <= fifo_ready_status_reg;
			end else if (rd_act_reg) begin
				O_DATA <= stage_mem_reg ? mem_rdata : stage_reg;
			end
			O_DATA_OE <= !I_STATUS_READ_SELECT_N || (rd_act_reg && rd_act);
		end
	end

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);

	sequence s_xon_write;
		wr_xon_char_one && I_CH == 2'h0;
	endsequence
	sequence s_xon_read;
		rd_start && I_ADDR == urs_pkg::OFS_XON_CHAR_ONE && I_CH == 2'h0;
	endsequence

	a_fifo_ready_status_tx_bits: assert property (
		##1 fifo_ready_status_reg[3:0] == ~$past(O_TX_SPACE_READY_N))
		else $error("status low nibble not inverted transmit ready");
	a_fifo_ready_status_rx_bits: assert property (
		##1 fifo_ready_status_reg[7:4] == $past(O_RX_DATA_READY_N))
		else $error("status high nibble not receive ready");
	a_status_select_bus: assert property (
		!I_STATUS_READ_SELECT_N |=> O_DATA_OE && O_DATA == $past(fifo_ready_status_reg))
		else $error("status byte not driven while selected");
	a_xon_write_lands: assert property (
		s_xon_write |=> xon_char_one_reg[0] == $past(I_DATA))
		else $error("flow character write did not land");
	a_xon_readback: assert property (
		s_xon_read |=> stage_reg == $past(xon_char_one_reg[0]))
		else $error("flow character did not read back");
	a_msr_high_follow: assert property (
		##1 msr_hi_reg[0] == ~$past(I_MODEM_N[0]))
		else $error("modem status high bits not inverted inputs");
	a_reset_status_vals: assert property (disable iff (1'b0)
		$rose(I_RST_N) |-> stat_reg[0].interrupt_source_reg == urs_pkg::RST_ISR &&
		stat_reg[NCH-1].line_status_reg == urs_pkg::RST_LSR && fifo_ready_status_reg == urs_pkg::RST_FIFO_READY_STATUS)
		else $error("status defaults wrong after reset");
	a_reset_ctl_vals: assert property (disable iff (1'b0)
		$rose(I_RST_N) |-> spr_reg[NCH-1] == urs_pkg::RST_SPR &&
		xoff_char_two_reg[0] == urs_pkg::RST_ZERO && efr_reg[NCH-1] == urs_pkg::RST_ZERO)
		else $error("control defaults wrong after reset");
	a_reset_pin_vals: assert property (disable iff (1'b0)
		$rose(I_RST_N) |-> O_TX == '1 && O_INFRARED_TX_OUT == '0 && O_RTS_N == '1 &&
		O_RX_DATA_READY_N == '1 && O_TX_SPACE_READY_N == '0 && O_IRQ_N &&
		O_INT_OE == !TRISTATE_INT)
		else $error("pin defaults wrong after reset");
endmodule // urs_bank

// *** urs_pkg.sv ***
// Purpose: Shared constants and types for the quad UART reset defaults and FIFO status bank.
// Assumes: One clock, asynchronous active-low reset, synchronous host strobes.
// Notes: Offsets are register indexes on the 5-bit host address.
package urs_pkg;
	localparam int NCH = 4;
	localparam int AW = 5;
	localparam int DW = 8;

	localparam logic [4:0] OFS_HOLD = 5'h00;
	localparam logic [4:0] OFS_IER = 5'h01;
	localparam logic [4:0] OFS_ISR = 5'h02;
	localparam logic [4:0] OFS_LCR = 5'h03;
	localparam logic [4:0] OFS_MCR = 5'h04;
	localparam logic [4:0] OFS_LSR = 5'h05;
	localparam logic [4:0] OFS_MSR = 5'h06;
	localparam logic [4:0] OFS_SPR = 5'h07;
	localparam logic [4:0] OFS_DLL = 5'h08;
	localparam logic [4:0] OFS_DLM = 5'h09;
	localparam logic [4:0] OFS_ENHANCED_MODE_SELECT_REG = 5'h0a;
	localparam logic [4:0] OFS_FIFO_LEVEL_REG = 5'h0b;
	localparam logic [4:0] OFS_TRG = 5'h0c;
	localparam logic [4:0] OFS_FCNT = 5'h0d;
	localparam logic [4:0] OFS_FEATURE_CONTROL_REG = 5'h0e;
	localparam logic [4:0] OFS_EFR = 5'h0f;
	localparam logic [4:0] OFS_XON_CHAR_ONE = 5'h10;
	localparam logic [4:0] OFS_XON_CHAR_TWO = 5'h11;
	localparam logic [4:0] OFS_XOFF_CHAR_ONE = 5'h12;
	localparam logic [4:0] OFS_XOFF_CHAR_TWO = 5'h13;

	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_ISR = 8'h01;
	localparam logic [7:0] RST_LSR = 8'h60;
	localparam logic [7:0] RST_SPR = 8'hff;
	localparam logic [7:0] RST_FIFO_READY_STATUS = 8'hff;
	localparam logic [3:0] RST_DELTA = 4'h0;

	localparam int MCR_DTR_BIT = 0;
	localparam int MCR_RTS_BIT = 1;
	localparam int ISR_NONE_BIT = 0;
	localparam int FEATURE_CONTROL_REG_SWAP_BIT = 6;

	localparam logic [1:0] SLOT_DLL = 2'h0;
	localparam logic [1:0] SLOT_DLM = 2'h1;
	localparam logic [1:0] SLOT_THR = 2'h2;
	localparam logic [1:0] SLOT_RHR = 2'h3;

	typedef struct packed {
		logic [7:0] interrupt_source_reg;
		logic [7:0] line_status_reg;
		logic [7:0] fifo_level_reg;
		logic [7:0] fcnt;
		logic [3:0] delta;
	} urs_stat_t;
endpackage

// *** urs_mem.sv ***
// Purpose: Small byte store for divisor and holding bytes, with a registered read.
// Assumes: One write port and one read port on the same clock.
// Notes: The array has no reset, so its contents are undefined until written.
`timescale 1ns/1ps
module urs_mem #(
	parameter int W = 8,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [W-1:0] i_wdata,
	input wire logic [AW-1:0] i_raddr,
	output logic [W-1:0] o_rdata
);
	logic [W-1:0] mem [DEPTH];

	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= '0;
		end else begin
			o_rdata <= mem[i_raddr];
		end
	end
endmodule // urs_mem

// *** urs_host.sv ***
// Purpose: Host processor model for the register bus and the status select.
// Assumes: Requests change just after a falling edge and are held across rising edges.
// Notes: The write data lines show the inverse of the last byte once released.
`timescale 1ns/1ps
module urs_host (
	input wire logic i_clk,
	input wire logic [7:0] i_data,
	input wire logic i_data_oe,
	output logic o_cs_n,
	output logic o_rd_n,
	output logic o_wr_n,
	output logic o_sel_n,
	output logic [1:0] o_ch,
	output logic [4:0] o_addr,
	output logic [7:0] o_wdata
);
	initial begin
		o_cs_n = 1'b1;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_sel_n = 1'b1;
		o_ch = 2'h0;
		o_addr = 5'h00;
		o_wdata = 8'h00;
	end
	task automatic wr(input logic [1:0] ch, input logic [4:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_ch = ch;
		o_addr = a;
		o_wdata = d;
		o_cs_n = 1'b0;
		o_wr_n = 1'b0;
		@(negedge i_clk);
		o_cs_n = 1'b1;
		o_wr_n = 1'b1;
		o_wdata = ~d;
		@(negedge i_clk);
	endtask
	// Waits a bounded number of edges for the bus to be driven, then takes the byte.
	task automatic take(output logic [7:0] d, output bit ok);
		ok = 1'b0;
		d = 8'h00;
		for (int n = 0; n < 4 && !ok; n++) begin
			@(posedge i_clk);
			#1;
			if (i_data_oe === 1'b1) begin
				ok = 1'b1;
				d = i_data;
			end
		end
	endtask
	task automatic rd(input logic [1:0] ch, input logic [4:0] a, output logic [7:0] d,
			output bit ok);
		@(negedge i_clk);
		o_ch = ch;
		o_addr = a;
		o_cs_n = 1'b0;
		o_rd_n = 1'b0;
		take(d, ok);
		@(negedge i_clk);
		o_cs_n = 1'b1;
		o_rd_n = 1'b1;
		@(negedge i_clk);
	endtask
	task automatic stat(output logic [7:0] d, output bit ok);
		@(negedge i_clk);
		o_sel_n = 1'b0;
		take(d, ok);
		@(negedge i_clk);
		o_sel_n = 1'b1;
		@(negedge i_clk);
	endtask
endmodule // urs_host

// *** uart_reset_and_fifo_status_test.sv ***
// Purpose: Self-checking bench for reset defaults, flow characters and FIFO status.
// Assumes: Inputs change on the falling edge; the host model owns the bus.
// Notes: Undefined divisor and holding bytes are not compared.
`timescale 1ns/1ps
module uart_reset_and_fifo_status_test;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0][3:0] modem_n = 16'h8765;
	urs_pkg::urs_stat_t [3:0] stat;
	logic [3:0] tx_space = 4'hf;
	logic [3:0] rx_avail = 4'h0;
	logic [3:0] tx_ser = 4'hf;
	logic [3:0] ir_ser = 4'h0;
	logic alt_mode = 1'b1;
	logic style_sel = 1'b0;
	logic cs_n, rd_n, wr_n, sel_n, oe, o_int, int_oe, irq_n, irq_oe;
	logic [1:0] ch;
	logic [4:0] addr;
	logic [7:0] wdata, rdata, got;
	logic [3:0] tx, ir, rts_n, dtr_n, txr_n, rxr_n;
	int fails = 0;
	int check_count = 0;
	bit ok;
	logic [4:0] ra [13] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h0a, 5'h0b, 5'h0c,
		5'h0d, 5'h0e, 5'h0f, 5'h10};
	logic [7:0] rv [13] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'hff, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00};
	logic [4:0] wa [10] = '{5'h01, 5'h03, 5'h0a, 5'h0c, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12,
		5'h13};
	initial begin
		forever #10 clk = ~clk;
	end
	initial begin
		for (int c = 0; c < 4; c++) begin
			stat[c] = '{interrupt_source_reg: 8'h01, line_status_reg: 8'h60, fifo_level_reg: 8'h00, fcnt: 8'h00, delta: 4'h0};
		end
	end
	urs_host host (.i_clk(clk), .i_data(rdata), .i_data_oe(oe), .o_cs_n(cs_n), .o_rd_n(rd_n),
		.o_wr_n(wr_n), .o_sel_n(sel_n), .o_ch(ch), .o_addr(addr), .o_wdata(wdata));
	urs_bank #(.TRISTATE_INT(1'b1), .NCH(4)) DUT (.I_CLK(clk), .I_RST_N(rst_n), .I_CS_N(cs_n),
		.I_CH(ch), .I_ADDR(addr), .I_RD_N(rd_n), .I_WR_N(wr_n), .I_DATA(wdata),
		.I_STATUS_READ_SELECT_N(sel_n), .I_BUS_ALT_MODE(alt_mode),
		.I_INTERRUPT_STYLE_SELECT(style_sel),
		.I_MODEM_N(modem_n), .I_STAT(stat), .I_TX_SPACE(tx_space), .I_RX_AVAIL(rx_avail),
		.I_TX_SER(tx_ser), .I_IR_SER(ir_ser), .O_DATA(rdata), .O_DATA_OE(oe), .O_TX(tx),
		.O_INFRARED_TX_OUT(ir), .O_RTS_N(rts_n), .O_DTR_N(dtr_n), .O_TX_SPACE_READY_N(txr_n),
		.O_RX_DATA_READY_N(rxr_n), .O_INT(o_int), .O_INT_OE(int_oe), .O_IRQ_N(irq_n),
		.O_IRQ_N_OE(irq_oe));
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk_reg(input logic [7:0] g, input logic [7:0] e, input bit k);
		check_count++;
		if (!k || g !== e) begin
			fails++;
			$display("ERROR at %0t: read %h, expected %h", $time, g, e);
		end
	endtask
	task automatic chk_pin(input logic [3:0] g, input logic [3:0] e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("ERROR at %0t: pins %h, expected %h", $time, g, e);
		end
	endtask
	task automatic rd_chk(input logic [1:0] c, input logic [4:0] a, input logic [7:0] e);
		host.rd(c, a, got, ok);
		chk_reg(got, e, ok);
	endtask
	task automatic st_chk(input logic [7:0] e);
		host.stat(got, ok);
		chk_reg(got, e, ok);
	endtask
	// Pins are looked at while reset is still held, so defaults must not wait for release.
	task automatic reset_pins();
		chk_pin(tx, 4'hf);
		chk_pin(ir, 4'h0);
		chk_pin(rts_n, 4'hf);
		chk_pin(dtr_n, 4'hf);
		chk_pin(rxr_n, 4'hf);
		chk_pin(txr_n, 4'h0);
		chk_pin({2'h0, o_int, int_oe}, 4'h0);
		chk_pin({3'h0, irq_n}, 4'h1);
	endtask
	initial begin
		repeat (8) @(negedge clk);
		reset_pins();
		rst_n = 1'b1;
		st_chk(8'hff);
		chk_pin({2'h0, irq_oe, irq_n}, 4'h3);
		for (int c = 0; c < 4; c++) begin
			for (int i = 0; i < 13; i++) begin
				rd_chk(c[1:0], ra[i], rv[i]);
			end
			rd_chk(c[1:0], 5'h06, {~modem_n[c], 4'h0});
		end
		$display("test reset_values done");
		for (int c = 0; c < 4; c++) begin
			for (int i = 0; i < 10; i++) begin
				host.wr(c[1:0], wa[i], {3'h0, wa[i]} + 8'(c));
			end
			host.wr(c[1:0], 5'h05, 8'h00);
			for (int i = 0; i < 10; i++) begin
				rd_chk(c[1:0], wa[i], {3'h0, wa[i]} + 8'(c));
			end
			rd_chk(c[1:0], 5'h05, 8'h60);
			rd_chk(c[1:0], 5'h1f, 8'h00);
		end
		// Swap mode moves the scratchpad slot to the count and the mode select.
		stat[3].fcnt = 8'h2a;
		host.wr(2'h3, 5'h0e, 8'h40);
		rd_chk(2'h3, 5'h07, 8'h2a);
		host.wr(2'h3, 5'h07, 8'h5a);
		rd_chk(2'h3, 5'h0a, 8'h5a);
		host.wr(2'h3, 5'h0e, 8'h00);
		rd_chk(2'h3, 5'h07, 8'hff);
		host.wr(2'h1, 5'h04, 8'h01);
		chk_pin(dtr_n, 4'hd);
		chk_pin(rts_n, 4'hf);
		host.wr(2'h2, 5'h04, 8'h02);
		chk_pin(rts_n, 4'hb);
		chk_pin(dtr_n, 4'hd);
		$display("test flow_chars done");
		tx_space = 4'b0101;
		rx_avail = 4'b0011;
		repeat (3) @(negedge clk);
		chk_pin(txr_n, 4'b1010);
		st_chk(8'hc5);
		$display("test fifo_status done");
		stat[2].interrupt_source_reg = 8'h04;
		repeat (3) @(negedge clk);
		chk_pin({o_int, int_oe, irq_oe, irq_n}, 4'b1110);
		rd_chk(2'h2, 5'h02, 8'h04);
		alt_mode = 1'b0;
		repeat (2) @(negedge clk);
		chk_pin({3'h0, irq_oe}, 4'h0);
		alt_mode = 1'b1;
		style_sel = 1'b1;
		repeat (2) @(negedge clk);
		chk_pin({3'h0, irq_oe}, 4'h0);
		style_sel = 1'b0;
		tx_ser = 4'h0;
		ir_ser = 4'hf;
		repeat (2) @(negedge clk);
		chk_pin(tx, 4'h0);
		chk_pin(ir, 4'hf);
		$display("test interrupt_pins done");
		modem_n = 16'h1234;
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		reset_pins();
		rst_n = 1'b1;
		for (int c = 0; c < 4; c++) begin
			rd_chk(c[1:0], 5'h10, 8'h00);
			rd_chk(c[1:0], 5'h04, 8'h00);
			rd_chk(c[1:0], 5'h06, {~modem_n[c], 4'h0});
		end
		$display("test second_reset done");
		stop_test();
	end
endmodule // uart_reset_and_fifo_status_test
